// ---- design/sacc_ctrl.sv ----
// converter control register, start source selection, burst and flag logic
`timescale 1ns/1ns
`include "sacc_defs.svh"
module sacc_ctrl (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CE_I,
  input  wire logic [7:0]  SFR_PAGE_I,
  input  wire logic [7:0]  SFR_ADDR_I,
  input  wire logic        SFR_WR_I,
  input  wire logic [7:0]  SFR_WDATA_I,
  input  wire logic        SFR_BIT_WR_I,
  input  wire logic [2:0]  SFR_BIT_SEL_I,
  input  wire logic        SFR_BIT_VAL_I,
  input  wire logic        TIMER0_OVF_I,
  input  wire logic        TIMER2_OVF_I,
  input  wire logic        TIMER3_OVF_I,
  input  wire logic        EXTERNAL_START_PIN_I,
  input  wire logic        LOW_POWER_SELECT_I,
  input  wire logic [4:0]  POWER_UP_TIME_I,
  input  wire logic [4:0]  SAR_DIV_I,
  input  wire logic        MODE_8BIT_I,
  input  wire logic [2:0]  REPEAT_COUNT_I,
  input  wire logic [9:0]  SAR_DATA_I,
  input  wire logic [15:0] UPPER_LIMIT_I,
  input  wire logic [15:0] LOWER_LIMIT_I,
  output logic      [7:0]  SFR_RDATA_O,
  output logic      [15:0] RESULT_O,
  output logic             ANALOG_ON_O,
  output logic             LOW_BIAS_O
);
  function automatic logic [6:0] repeat_total(input logic [2:0] code);
    unique case (code)
      3'h0:    repeat_total = 7'h01;
      3'h1:    repeat_total = 7'h04;
      3'h2:    repeat_total = 7'h08;
      3'h3:    repeat_total = 7'h10;
      3'h4:    repeat_total = 7'h20;
      default: repeat_total = 7'h40;
    endcase
  endfunction : repeat_total

  sacc_seq_if s ();
  sacc_seq u_seq (.clock_i(CLOCK_I), .rst_n_i(RST_N_I), .ce_i(CE_I), .s(s.seq));

  logic [7:0]  ctrl, next_ctrl;
  logic [2:0]  ext_sync;
  logic        ext_lvl, next_ext_lvl;
  logic [6:0]  burst_left, next_burst_left;
  logic [6:0]  acc_n, next_acc_n;
  logic [15:0] acc, next_acc;
  logic        start, next_start;
  logic        pwrup, next_pwrup;
  logic [7:0]  next_rdata;
  logic [15:0] next_result;
  logic        next_analog_on;
  logic        sel, wr_any, sw_start, ext_rise, start_evt, accept, target_hit, in_window;
  logic [7:0]  wv;
  logic [6:0]  target;
  logic [15:0] sample, sum;

  assign s.start      = start;
  assign s.need_pwrup = pwrup;
  assign s.conv_clks  = MODE_8BIT_I ? `SACC_CLKS_8BIT : `SACC_CLKS_10BIT;
  assign s.pwrup_time = POWER_UP_TIME_I;
  assign s.sar_div    = SAR_DIV_I;

  ////////////////////////////////////////////////////////////////////////////
  // register write decode and start sources
  always_comb begin
    sel    = (SFR_PAGE_I == `SACC_CTRL_PAGE) && (SFR_ADDR_I == `SACC_CTRL_ADDR);
    wr_any = sel && (SFR_WR_I || SFR_BIT_WR_I);
    wv     = SFR_BIT_WR_I ? ctrl : SFR_WDATA_I;
    if (SFR_BIT_WR_I) begin
      wv[SFR_BIT_SEL_I] = SFR_BIT_VAL_I;
    end
    // the written source field must be 000 as well as the stored one
    sw_start = wr_any && wv[`SACC_BIT_TRIG] && (wv[2:0] == `SACC_SRC_SW);
    ext_rise = next_ext_lvl && !ext_lvl;
    unique casez (ctrl[2:0])
      `SACC_SRC_SW: start_evt = sw_start;
      `SACC_SRC_T0: start_evt = TIMER0_OVF_I;
      `SACC_SRC_T2: start_evt = TIMER2_OVF_I;
      `SACC_SRC_T3: start_evt = TIMER3_OVF_I;
      3'b1??:       start_evt = ext_rise;
      default:      start_evt = 1'b0;
    endcase
    // disabled single mode ignores starts; burst wakes itself
    accept = start_evt && (ctrl[`SACC_BIT_ON] || ctrl[`SACC_BIT_BURST])
             && !s.busy && !start && (burst_left == 7'h00);
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser filter: level follows only when stages two and three agree
  always_comb begin
    next_ext_lvl = (ext_sync[1] == ext_sync[2]) ? ext_sync[2] : ext_lvl;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing, accumulation and flags
  always_comb begin
    target      = ctrl[`SACC_BIT_BURST] ? repeat_total(REPEAT_COUNT_I) : 7'h01;
    sample      = MODE_8BIT_I ? {6'h00, SAR_DATA_I[9:2], 2'b00} : {6'h00, SAR_DATA_I};
    sum         = 16'(acc + sample);
    target_hit  = s.done && (7'(acc_n + 7'h01) >= target);
    in_window   = (sum > UPPER_LIMIT_I) && (sum < LOWER_LIMIT_I);
    next_ctrl       = ctrl;
    next_burst_left = burst_left;
    next_acc_n      = acc_n;
    next_acc        = acc;
    next_result     = RESULT_O;
    next_start      = 1'b0;
    next_pwrup      = pwrup;
    if (wr_any) begin
      next_ctrl = {wv[7:5], 1'b0, wv[3:0]};
    end
    if (accept) begin
      // a pin edge in burst only buys one conversion of the count
      next_burst_left = (ctrl[2] || !ctrl[`SACC_BIT_BURST]) ? 7'h01 : target;
      next_start      = 1'b1;
      next_pwrup      = ctrl[`SACC_BIT_BURST] && !ctrl[`SACC_BIT_ON];
    end
    if (s.done) begin
      next_burst_left = 7'(burst_left - 7'h01);
      next_pwrup      = 1'b0;
      if (target_hit) begin
        next_acc    = 16'h0000;
        next_acc_n  = 7'h00;
        next_result = sum;
        next_ctrl[`SACC_BIT_DONE] = 1'b1;
        if (in_window) begin
          next_ctrl[`SACC_BIT_WIN] = 1'b1;
        end
      end else begin
        next_acc   = sum;
        next_acc_n = 7'(acc_n + 7'h01);
      end
      if (burst_left > 7'h01 && !target_hit) begin
        next_start = 1'b1;
      end
    end
    next_rdata = ctrl;
    next_rdata[`SACC_BIT_TRIG] = s.busy || start;
    next_analog_on = ctrl[`SACC_BIT_ON] || s.busy || start;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ctrl        <= `SACC_CTRL_RESET;
      ext_sync    <= 3'h0;
      ext_lvl     <= 1'b0;
      burst_left  <= 7'h00;
      acc_n       <= 7'h00;
      acc         <= 16'h0000;
      start       <= 1'b0;
      pwrup       <= 1'b0;
      SFR_RDATA_O <= `SACC_CTRL_RESET;
      RESULT_O    <= 16'h0000;
      ANALOG_ON_O <= 1'b0;
      LOW_BIAS_O  <= 1'b0;
    end else if (CE_I) begin
      ctrl        <= next_ctrl;
      ext_sync    <= {ext_sync[1:0], EXTERNAL_START_PIN_I};
      ext_lvl     <= next_ext_lvl;
      burst_left  <= next_burst_left;
      acc_n       <= next_acc_n;
      acc         <= next_acc;
      start       <= next_start;
      pwrup       <= next_pwrup;
      SFR_RDATA_O <= next_rdata;
      RESULT_O    <= next_result;
      ANALOG_ON_O <= next_analog_on;
      LOW_BIAS_O  <= LOW_POWER_SELECT_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I || !CE_I);

  a_low_bias_follow: assert property (LOW_POWER_SELECT_I |=> LOW_BIAS_O)
    else $error("low bias output does not follow the select input");
  a_off_no_start: assert property (
    start_evt && !ctrl[`SACC_BIT_ON] && !ctrl[`SACC_BIT_BURST] && !s.busy |=> !start)
    else $error("disabled converter accepted a start");
  a_done_flag_set: assert property (target_hit |=> ctrl[`SACC_BIT_DONE])
    else $error("completion flag not set at end of conversion count");
  a_flags_sticky: assert property (
    ctrl[`SACC_BIT_DONE] && !wr_any |=> ctrl[`SACC_BIT_DONE])
    else $error("completion flag cleared without software");
  a_sw_trigger: assert property (
    sw_start && ctrl[2:0] == `SACC_SRC_SW && accept |=> start ##1 s.busy)
    else $error("software trigger did not start a conversion");
  a_trigger_mode: assert property (
    wr_any && wv[`SACC_BIT_TRIG] && ctrl[2:0] != `SACC_SRC_SW && !start_evt && !s.done |=> !start)
    else $error("trigger bit started a conversion in another source mode");
  a_window_flag: assert property (target_hit && in_window |=> ctrl[`SACC_BIT_WIN])
    else $error("window flag not set for result inside limits");
  a_burst_count: assert property (
    accept && ctrl[`SACC_BIT_BURST] && !ctrl[2] |=> burst_left == $past(target))
    else $error("burst did not load the repeat count");
  a_ext_single: assert property (
    accept && ctrl[`SACC_BIT_BURST] && ctrl[2] |=> burst_left == 7'h01)
    else $error("pin edge in burst loaded more than one conversion");
  a_result_first: assert property (
    $rose(ctrl[`SACC_BIT_DONE]) && !$past(wr_any && wv[`SACC_BIT_DONE])
    |-> RESULT_O == $past(sum))
    else $error("completion flag raised before the result was loaded");

  c_burst_done: cover property (ctrl[`SACC_BIT_BURST] && target_hit && target > 7'h01);
  c_window_hit: cover property (target_hit && in_window);
  c_ext_start:  cover property (accept && ctrl[2]);
  c_set_clear:  cover property (target_hit && wr_any && !wv[`SACC_BIT_DONE]);
endmodule : sacc_ctrl

// ---- design/sacc_defs.svh ----
// constants for the converter control block
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH

`define SACC_CTRL_ADDR    8'hE8
`define SACC_CTRL_PAGE    8'h00
`define SACC_CTRL_RESET   8'h00
`define SACC_BIT_ON       3'h7
`define SACC_BIT_BURST    3'h6
`define SACC_BIT_DONE     3'h5
`define SACC_BIT_TRIG     3'h4
`define SACC_BIT_WIN      3'h3
`define SACC_SRC_SW       3'h0
`define SACC_SRC_T0       3'h1
`define SACC_SRC_T2       3'h2
`define SACC_SRC_T3       3'h3
`define SACC_CLKS_8BIT    4'hB
`define SACC_CLKS_10BIT   4'hD

`endif

// ---- design/sacc_pkg.sv ----
// types for the converter control block
package sacc_pkg;
  typedef enum logic [1:0] {
    SACC_IDLE  = 2'b00,
    SACC_PWRUP = 2'b01,
    SACC_CONV  = 2'b10
  } sacc_seq_state_type;
endpackage : sacc_pkg

// ---- design/sacc_seq_if.sv ----
// control and status between the register logic and the conversion sequencer
`timescale 1ns/1ns
interface sacc_seq_if;
  logic       start;
  logic       need_pwrup;
  logic [3:0] conv_clks;
  logic [4:0] pwrup_time;
  logic [4:0] sar_div;
  logic       busy;
  logic       done;
  modport ctrl (output start, need_pwrup, conv_clks, pwrup_time, sar_div, input busy, done);
  modport seq  (input start, need_pwrup, conv_clks, pwrup_time, sar_div, output busy, done);
endinterface : sacc_seq_if

// ---- design/sacc_seq.sv ----
// conversion sequencer: SAR clock divider, power-up wait and conversion length
`timescale 1ns/1ns
module sacc_seq (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  sacc_seq_if.seq   s
);
  sacc_pkg::sacc_seq_state_type state, next_state;
  logic [4:0] div_cnt, next_div_cnt;
  logic [4:0] cnt, next_cnt;
  logic       done, next_done;
  logic       tick;
  logic [4:0] ticks_seen;

  assign s.busy = (state != sacc_pkg::SACC_IDLE);
  assign s.done = done;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    tick         = (div_cnt == s.sar_div);
    next_state   = state;
    next_div_cnt = div_cnt;
    next_cnt     = cnt;
    next_done    = 1'b0;
    if (state != sacc_pkg::SACC_IDLE) begin
      next_div_cnt = tick ? 5'h00 : 5'(div_cnt + 5'h01);
    end
    unique case (state)
      sacc_pkg::SACC_IDLE: begin
        if (s.start) begin
          next_div_cnt = 5'h00;
          if (s.need_pwrup && s.pwrup_time != 5'h00) begin
            next_state = sacc_pkg::SACC_PWRUP;
            next_cnt   = s.pwrup_time;
          end else begin
            next_state = sacc_pkg::SACC_CONV;
            next_cnt   = {1'b0, s.conv_clks};
          end
        end
      end
      sacc_pkg::SACC_PWRUP: begin
        if (tick) begin
          if (cnt == 5'h01) begin
            next_state = sacc_pkg::SACC_CONV;
            next_cnt   = {1'b0, s.conv_clks};
          end else begin
            next_cnt = 5'(cnt - 5'h01);
          end
        end
      end
      sacc_pkg::SACC_CONV: begin
        if (tick) begin
          if (cnt == 5'h01) begin
            next_state = sacc_pkg::SACC_IDLE;
            next_done  = 1'b1;
          end else begin
            next_cnt = 5'(cnt - 5'h01);
          end
        end
      end
      default: next_state = sacc_pkg::SACC_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state   <= sacc_pkg::SACC_IDLE;
      div_cnt <= 5'h00;
      cnt     <= 5'h00;
      done    <= 1'b0;
    end else if (ce_i) begin
      state   <= next_state;
      div_cnt <= next_div_cnt;
      cnt     <= next_cnt;
      done    <= next_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper: SAR ticks seen while converting
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ticks_seen <= 5'h00;
    end else if (ce_i) begin
      if (state != sacc_pkg::SACC_CONV) begin
        ticks_seen <= 5'h00;
      end else if (tick) begin
        ticks_seen <= 5'(ticks_seen + 5'h01);
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i || !ce_i);

  a_conv_length: assert property (done |-> ticks_seen == {1'b0, $past(s.conv_clks)})
    else $error("conversion length differs from the selected clock count");
  a_pwrup_entry: assert property (
    !s.busy && s.start && s.need_pwrup && s.pwrup_time != 5'h00 |=> state == sacc_pkg::SACC_PWRUP)
    else $error("power-up wait skipped");
  c_pwrup: cover property (state == sacc_pkg::SACC_PWRUP ##1 state == sacc_pkg::SACC_CONV);
endmodule : sacc_seq

// ---- bench/testbench.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ns
module testbench;
  logic        CLOCK_I, RST_N_I, CE_I, SFR_WR_I, SFR_BIT_WR_I, SFR_BIT_VAL_I;
  logic        TIMER0_OVF_I, TIMER2_OVF_I, TIMER3_OVF_I, EXTERNAL_START_PIN_I;
  logic        LOW_POWER_SELECT_I, MODE_8BIT_I, ANALOG_ON_O, LOW_BIAS_O, on;
  logic [7:0]  SFR_PAGE_I, SFR_ADDR_I, SFR_WDATA_I, SFR_RDATA_O;
  logic [2:0]  SFR_BIT_SEL_I, REPEAT_COUNT_I, s;
  logic [4:0]  POWER_UP_TIME_I, SAR_DIV_I;
  logic [9:0]  SAR_DATA_I;
  logic [15:0] UPPER_LIMIT_I, LOWER_LIMIT_I, RESULT_O;
  int          fails, n_checks, n, nres;

  sacc_ctrl i_dut (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
    .SFR_PAGE_I(SFR_PAGE_I), .SFR_ADDR_I(SFR_ADDR_I), .SFR_WR_I(SFR_WR_I),
    .SFR_WDATA_I(SFR_WDATA_I), .SFR_BIT_WR_I(SFR_BIT_WR_I), .SFR_BIT_SEL_I(SFR_BIT_SEL_I),
    .SFR_BIT_VAL_I(SFR_BIT_VAL_I), .TIMER0_OVF_I(TIMER0_OVF_I), .TIMER2_OVF_I(TIMER2_OVF_I),
    .TIMER3_OVF_I(TIMER3_OVF_I), .EXTERNAL_START_PIN_I(EXTERNAL_START_PIN_I),
    .LOW_POWER_SELECT_I(LOW_POWER_SELECT_I), .POWER_UP_TIME_I(POWER_UP_TIME_I),
    .SAR_DIV_I(SAR_DIV_I), .MODE_8BIT_I(MODE_8BIT_I), .REPEAT_COUNT_I(REPEAT_COUNT_I),
    .SAR_DATA_I(SAR_DATA_I), .UPPER_LIMIT_I(UPPER_LIMIT_I), .LOWER_LIMIT_I(LOWER_LIMIT_I),
    .SFR_RDATA_O(SFR_RDATA_O), .RESULT_O(RESULT_O), .ANALOG_ON_O(ANALOG_ON_O),
    .LOW_BIAS_O(LOW_BIAS_O));

  initial begin
    CLOCK_I = 1'h0;
    forever #25 CLOCK_I = ~CLOCK_I;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLOCK_I);
    SFR_ADDR_I = a;
    SFR_WDATA_I = d;
    SFR_WR_I = 1'h1;
    @(negedge CLOCK_I);
    SFR_WR_I = 1'h0;
    SFR_ADDR_I = 8'hE8;
  endtask : wr

  task automatic bwr(input logic [2:0] b, input logic v);
    @(negedge CLOCK_I);
    SFR_BIT_SEL_I = b;
    SFR_BIT_VAL_I = v;
    SFR_BIT_WR_I = 1'h1;
    @(negedge CLOCK_I);
    SFR_BIT_WR_I = 1'h0;
  endtask : bwr

  task automatic pulse(input logic [2:0] src);
    @(negedge CLOCK_I);
    TIMER0_OVF_I = (src == 3'h1);
    TIMER2_OVF_I = (src == 3'h2);
    TIMER3_OVF_I = (src == 3'h3);
    EXTERNAL_START_PIN_I = src[2];
    @(negedge CLOCK_I);
    {TIMER0_OVF_I, TIMER2_OVF_I, TIMER3_OVF_I} = 3'h0;
    // pin held a few cycles so the synchroniser surely sees it; timers return at once
    if (src[2])
      repeat (5) @(negedge CLOCK_I);
    EXTERNAL_START_PIN_I = 1'h0;
  endtask : pulse

  // start with control byte c, then count edges to result change and done flag
  task automatic run(input logic [7:0] c);
    logic [15:0] r0;
    r0 = RESULT_O;
    // enable and source are stored first: the trigger is judged against the stored byte
    wr(8'hE8, c);
    if (c[2:0] == 3'h0)
      wr(8'hE8, c | 8'h10);
    else
      pulse(c[2:0]);
    n = 0;
    nres = 0;
    on = 1'h0;
    while (SFR_RDATA_O[5] !== 1'h1 && n < 3000) begin
      @(posedge CLOCK_I);
      n++;
      @(negedge CLOCK_I);
      if (RESULT_O !== r0 && nres == 0)
        nres = n;
      if (ANALOG_ON_O === 1'h1)
        on = 1'h1;
    end
    chk(nres != 0 && nres <= n, 1'h1);
    @(negedge CLOCK_I);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge CLOCK_I);
    fails++;
    $display("unexpected at %0t: run hung", $time);
    give_verdict();
  end

  initial begin
    {RST_N_I, SFR_WR_I, SFR_BIT_WR_I, SFR_BIT_VAL_I, LOW_POWER_SELECT_I} = 5'h0;
    {TIMER0_OVF_I, TIMER2_OVF_I, TIMER3_OVF_I, EXTERNAL_START_PIN_I, MODE_8BIT_I} = 5'h0;
    CE_I = 1'h1;
    {SFR_PAGE_I, SFR_WDATA_I} = 16'h0000;
    SFR_ADDR_I = 8'hE8;
    SFR_BIT_SEL_I = 3'h0;
    REPEAT_COUNT_I = 3'h0;
    POWER_UP_TIME_I = 5'h02;
    SAR_DIV_I = 5'h00;
    SAR_DATA_I = 10'h000;
    UPPER_LIMIT_I = 16'hFFFF;
    LOWER_LIMIT_I = 16'h0000;
    repeat (5) @(posedge CLOCK_I);
    @(negedge CLOCK_I);
    chk({SFR_RDATA_O, 7'h00, ANALOG_ON_O}, 16'h0000);
    chk(RESULT_O, 16'h0000);
    RST_N_I = 1'h1;
    SFR_PAGE_I = 8'h01;
    wr(8'hE8, 8'hC7);
    SFR_PAGE_I = 8'h00;
    wr(8'hE9, 8'hC7);
    LOW_POWER_SELECT_I = 1'h1;
    repeat (2) @(negedge CLOCK_I);
    chk(SFR_RDATA_O, 8'h00);
    chk(LOW_BIAS_O, 1'h1);
    LOW_POWER_SELECT_I = 1'h0;
    // converter off and single mode: a software start must be dropped
    wr(8'hE8, 8'h10);
    repeat (20) @(negedge CLOCK_I);
    chk({RESULT_O[14:0], ANALOG_ON_O}, 16'h0000);
    chk({SFR_RDATA_O, 7'h00, LOW_BIAS_O}, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      s = (i == 5) ? 3'h7 : 3'(i);
      SAR_DATA_I = 10'h101 + 10'(i * 16);
      if (s != 3'h0) begin
        wr(8'hE8, 8'h90 | s);
        repeat (20) @(negedge CLOCK_I);
        chk(RESULT_O, 16'h0101 + 16'((i - 1) * 16));
      end
      run(8'h80 | s);
      chk(RESULT_O, {6'h00, SAR_DATA_I});
      if (!s[2])
        chk(nres == 15, 1'h1);
      repeat (10) @(negedge CLOCK_I);
      chk(SFR_RDATA_O[5:3], 3'h4);
      bwr(3'h5, 1'h0);
      @(negedge CLOCK_I);
      chk(SFR_RDATA_O, 8'h80 | s);
    end
    MODE_8BIT_I = 1'h1;
    SAR_DATA_I = 10'h2FF;
    run(8'h80);
    chk(nres == 13, 1'h1);
    chk(RESULT_O, 16'h02FC);
    MODE_8BIT_I = 1'h0;
    // SAR clock slowed to 4 MHz, where low power is the advised setting
    {SAR_DIV_I, LOW_POWER_SELECT_I} = 6'h09;
    SAR_DATA_I = 10'h155;
    run(8'h80);
    chk(nres == 67, 1'h1);
    chk(RESULT_O, 16'h0155);
    chk(LOW_BIAS_O, 1'h1);
    {SAR_DIV_I, LOW_POWER_SELECT_I} = 6'h00;
    UPPER_LIMIT_I = 16'h0010;
    LOWER_LIMIT_I = 16'h0100;
    SAR_DATA_I = 10'h020;
    bwr(3'h5, 1'h0);
    run(8'h80);
    @(negedge CLOCK_I);
    chk(SFR_RDATA_O[3], 1'h1);
    bwr(3'h3, 1'h0);
    bwr(3'h5, 1'h0);
    SAR_DATA_I = 10'h300;
    run(8'h80);
    @(negedge CLOCK_I);
    chk(SFR_RDATA_O[3], 1'h0);
    {UPPER_LIMIT_I, LOWER_LIMIT_I} = 32'hFFFF0000;
    // burst of four with the converter normally off
    REPEAT_COUNT_I = 3'h1;
    SAR_DATA_I = 10'h011;
    bwr(3'h5, 1'h0);
    run(8'h40);
    chk(RESULT_O, 16'h0044);
    chk({on, n > 52}, 2'h3);
    repeat (3) @(negedge CLOCK_I);
    chk(ANALOG_ON_O, 1'h0);
    bwr(3'h5, 1'h0);
    wr(8'hE8, 8'h44);
    SAR_DATA_I = 10'h022;
    // pin edges spaced far wider than four clocks
    for (int k = 0; k < 4; k++) begin
      EXTERNAL_START_PIN_I = 1'h1;
      repeat (30) @(negedge CLOCK_I);
      EXTERNAL_START_PIN_I = 1'h0;
      repeat (30) @(negedge CLOCK_I);
      chk(SFR_RDATA_O[5], k == 3);
    end
    chk(RESULT_O, 16'h0088);
    give_verdict();
  end
endmodule : testbench
